/* File: inc/ref_dac_pkg.sv */
// Purpose: Constants and types for the reference level converter control.
// Assumes: Registers are eight bits wide on a plain strobe port.
// Notes: Register offsets are local choices, listed in the hand-over.
//
// Notes on behaviour
// [R1] Ladder powered only while enable bit set.
// [R2] Five-bit code gives exactly 32 levels.
// [R3] Level is negative plus span times code/32.
// [R4] Positive source supply, pin or fixed reference.
// [R5] Output routes to comparator, ADC, pins.
// [R6] Each pin carries level only when enabled.
// [R7] Reference pin loses driver, detector, pull-up.
// [R8] Digital read of reference pin returns zero.
// [R9] Converter keeps running during sleep.
// [R10] Wake from sleep keeps first register intact.
// [R11] Reset disables, frees pins, clears code.
// [R12] Enable bit 7, pin enables 5 and 4.
// [R13] Source field 00 supply, 01 pin, 10 fixed.
// [R14] Negative source bit reads as zero.
// [R15] Register writes reach ladder next edge.
package ref_dac_pkg;
    // ****************************************************************
    // Register map and field layout.
    // ****************************************************************
    localparam logic [1:0] ADDR_FIRST = 2'h0; // First control register.
    localparam logic [1:0] ADDR_SECOND = 2'h1; // Second, level select.
    localparam int BIT_ENABLE = 7; // Converter enable bit.
    localparam int BIT_OE1 = 5; // Pin 1 output enable.
    localparam int BIT_OE2 = 4; // Pin 2 output enable.
    localparam int BIT_PSS_HI = 3; // Positive source field top.
    localparam int BIT_PSS_LO = 2; // Positive source field bottom.
    localparam int CODE_W = 5; // Level select width.
    localparam int LEVELS = 32; // Number of output levels.
    localparam logic [7:0] FIRST_RESET = 8'h00; // Reset value, first.
    localparam logic [4:0] CODE_RESET = 5'h00; // Reset value, code.
    localparam logic [7:0] FIRST_WMASK = 8'hBC; // Writable bits.
    localparam logic [1:0] PSS_SUPPLY = 2'h0; // Supply as source.
    localparam logic [1:0] PSS_PIN = 2'h1; // External pin as source.
    localparam logic [1:0] PSS_FIXED = 2'h2; // Fixed reference.
    localparam logic [1:0] PSS_RSVD = 2'h3; // Reserved code.

    // Settings that travel together to the analogue ladder.
    typedef struct packed {
        logic enable; // Ladder powered.
        logic [1:0] pos_src; // Positive source select.
        logic neg_src; // Negative source select, always ground here.
        logic [4:0] code; // Level select code.
        logic pin1_out; // Level on pin 1.
        logic pin2_out; // Level on pin 2.
    } ladder_t;
endpackage

/* File: verif/ref_ladder_model.sv */
// Purpose: Behavioural resistor ladder and reference pin pair.
// Assumes: A pin's digital level is noise that changes every cycle.
// Notes: The level is an index in 1/32 steps of the source span.
`timescale 1ns/1ns
`default_nettype none
module ref_ladder_model
    import ref_dac_pkg::*;
(
    input wire logic clk,
    input wire ladder_t ladder,
    output logic [1:0] pin_lvl,
    output logic [5:0] level
);
    logic [1:0] pat_r = 2'h1; // Pattern seen by the pin input stage.
    // An unpowered ladder gives no level; otherwise code/32 of span.
    assign level = ladder.enable ? {1'b0, ladder.code} : 6'h00;
    // Toggling keeps a stale value from passing for a masked read.
    always @(posedge clk) pat_r <= ~pat_r;
    assign pin_lvl = pat_r;
endmodule
`default_nettype wire

/* File: verif/test_ref_dac_control.sv */
// Purpose: Self-checking bench for the reference converter control.
// Assumes: Registers at offsets 0 and 1; offsets 2 and 3 are unmapped.
// Notes: Random settings come from a fixed-seed xorshift generator.
`timescale 1ns/1ns
`default_nettype none
module test_ref_dac_control;
    import ref_dac_pkg::*;
    logic MCLK = 1'b0, RESET_N = 1'b0, WR = 1'b0, RD = 1'b0, SLEEP = 1'b0;
    logic [1:0] ADDR = 2'h0, PIN_IN, PIN_DIG_IN, drv_off, pu_off, ccd_off;
    logic [7:0] WDATA = 8'h00, RDATA, f;
    logic [4:0] c;
    logic [5:0] level;
    logic [31:0] seed = 32'he62fa4b9, r;
    ladder_t LADDER;
    int num_errors = 0, compares = 0;
    always #5 MCLK = ~MCLK;
    ref_dac_control ref_dac_control_inst (.MCLK(MCLK), .RESET_N(RESET_N),
        .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .SLEEP(SLEEP), .PIN_IN(PIN_IN), .PIN_DIG_IN(PIN_DIG_IN),
        .PIN_DRV_OFF(drv_off), .PIN_PULLUP_OFF(pu_off),
        .PIN_CCD_OFF(ccd_off), .LADDER(LADDER));
    ref_ladder_model ref_ladder_model_inst (.clk(MCLK), .ladder(LADDER),
        .pin_lvl(PIN_IN), .level(level));
    // ****************************************************************
    // Helpers: generator, bus cycle, comparison and closing report.
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected ladder settings for a pair of register values.
    function automatic ladder_t exp_ladder(logic [7:0] a, logic [4:0] b);
        return '{a[7], a[3:2], 1'b0, b, a[5], a[4]};
    endfunction
    // One bus cycle; strobes stay as set until the next call.
    task automatic bus(logic w, logic rr, logic [1:0] a, logic [7:0] d);
        WR <= w;
        RD <= rr;
        ADDR <= a;
        WDATA <= d;
        @(posedge MCLK);
    endtask
    task automatic check(logic [15:0] seen, logic [15:0] expect_v);
        compares++;
        if (seen !== expect_v) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, expect_v);
        end
    endtask
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Checks every port that follows the stored pair f, c.
    task automatic check_all();
        check(LADDER, exp_ladder(f, c));
        check(level, f[7] ? {1'b0, c} : 6'h00);
        check({drv_off, pu_off, ccd_off}, {3{f[4], f[5]}});
        check(PIN_DIG_IN, PIN_IN & ~{f[4], f[5]});
    endtask
    initial begin
        #100000;
        num_errors++;
        give_verdict();
    end
    // Main sequence: reset, random traffic, unmapped place, a reset every 20 rounds.
    initial begin
        f = 8'h00;
        c = 5'h00;
        repeat (12) @(posedge MCLK);
        RESET_N <= 1'b1;
        @(posedge MCLK);
        for (int i = 0; i < 60; i++) begin
            // Settings must still be the last written, or reset values.
            #1 check_all();
            r = rnd();
            // Corner cases first: all ones save the source field, then each usable source code.
            f = (i == 0) ? 8'hFF : r[7:0];
            if (i > 0 && i < 5) begin
                f = {r[7:4], i[1:0], r[1:0]};
            end
            // Software never writes the reserved source code.
            if (f[3:2] == PSS_RSVD) begin
                f[3:2] = PSS_SUPPLY;
            end
            c = (i == 0) ? 5'h1F : r[12:8];
            SLEEP <= r[20];
            bus(1'b1, 1'b0, ADDR_FIRST, f);
            bus(1'b1, 1'b0, ADDR_SECOND, {r[15:13], c});
            bus(1'b0, 1'b1, ADDR_FIRST, 8'h00);
            #1 check(RDATA, f & FIRST_WMASK);
            f = f & FIRST_WMASK;
            check_all();
            check(PIN_DIG_IN & {f[4], f[5]}, 2'h0);
            SLEEP <= ~SLEEP;
            bus(1'b0, 1'b1, ADDR_SECOND, 8'h00);
            #1 check(RDATA, {3'h0, c});
            bus(1'b1, 1'b0, 2'h2 | r[21], r[31:24]);
            bus(1'b0, 1'b1, 2'h2 | r[22], 8'h00);
            #1 check(RDATA, 8'h00);
            check_all();
            bus(1'b0, 1'b1, ADDR_FIRST, 8'h00);
            #1 check(RDATA, f);
            bus(1'b0, 1'b0, ADDR_FIRST, 8'h00);
            if (i % 20 == 19) begin
                RESET_N <= 1'b0;
                f = 8'h00;
                c = 5'h00;
                @(posedge MCLK);
                RESET_N <= 1'b1;
                @(posedge MCLK);
            end
        end
        give_verdict();
    end
endmodule
`default_nettype wire

/* File: verilog/ref_dac_control.sv */
// Purpose: Control registers and pin override for the reference converter.
// Assumes: One clock, asynchronous active-low reset, plain register port.
// Notes: Sleep is only an input; no state reacts to it.
`timescale 1ns/1ns
`default_nettype none
module ref_dac_control
    import ref_dac_pkg::*;
#(
    parameter int LEVEL_BITS = CODE_W
) (
    input wire logic MCLK,
    input wire logic RESET_N,
    input wire logic [1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic SLEEP,
    input wire logic [1:0] PIN_IN,
    output logic [1:0] PIN_DIG_IN,
    output logic [1:0] PIN_DRV_OFF,
    output logic [1:0] PIN_PULLUP_OFF,
    output logic [1:0] PIN_CCD_OFF,
    output ladder_t LADDER
);
    // ****************************************************************
    // Parameter check.
    // ****************************************************************
    // The ladder has exactly 32 taps, so no other width can be served.
    if (LEVEL_BITS != CODE_W || (1 << LEVEL_BITS) != LEVELS) begin : g_chk
        $error("Level code width must be five bits.");
    end

    // ****************************************************************
    // Registers.
    // ****************************************************************
    logic [7:0] first_r; // First control register, writable bits only.
    logic [7:0] first_nxt; // Next value of it.
    logic [4:0] code_r; // Level select code.
    logic [4:0] code_nxt; // Next value of it.
    logic [7:0] rdata_r; // Read data, valid the cycle after a read.
    logic [7:0] rdata_nxt; // Next value of it.

    // Reads show reserved bits and the negative source bit as zero.
    function automatic logic [7:0] read_mux(input logic [1:0] a,
                                            input logic [7:0] f,
                                            input logic [4:0] c);
        logic [7:0] v;
        v = 8'h00;
        if (a == ADDR_FIRST) begin
            v = f & FIRST_WMASK; // [R12] [R14]
        end else if (a == ADDR_SECOND) begin
            v = {3'h0, c};
        end
        return v;
    endfunction

    // Write decode; sleep and wake are deliberately not looked at so
    // the settings ride through sleep untouched.
    always_comb begin
        first_nxt = first_r; // [R9] [R10]
        code_nxt = code_r;
        rdata_nxt = 8'h00;
        if (WR && ADDR == ADDR_FIRST) begin
            first_nxt = WDATA & FIRST_WMASK; // [R12] [R13] [R15]
        end
        if (WR && ADDR == ADDR_SECOND) begin
            code_nxt = WDATA[4:0]; // [R2] [R15]
        end
        if (RD) begin
            rdata_nxt = read_mux(ADDR, first_r, code_r);
        end
    end

    // Reset disables the converter, frees the pins and clears the code.
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            first_r <= FIRST_RESET; // [R11]
            code_r <= CODE_RESET; // [R11]
            rdata_r <= 8'h00;
        end else begin
            first_r <= first_nxt;
            code_r <= code_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA = rdata_r;

    // ****************************************************************
    // Ladder and pin control.
    // ****************************************************************
    // The ladder computes negative plus span times code over 32 itself;
    // this block only hands it the source choice and the code.
    // Reserved source code 11 is passed as written; software must not
    // use it, and decoding it here would hide that misuse.
    always_comb begin
        LADDER.enable = first_r[BIT_ENABLE]; // [R1]
        LADDER.pos_src = first_r[BIT_PSS_HI:BIT_PSS_LO]; // [R4] [R13]
        LADDER.neg_src = 1'b0; // [R4] [R14]
        LADDER.code = code_r; // [R3] [R5]
        LADDER.pin1_out = first_r[BIT_OE1]; // [R6]
        LADDER.pin2_out = first_r[BIT_OE2]; // [R6]
    end

    // Number of pins that can carry the reference level.
    localparam int PIN_COUNT = 2;

    logic [PIN_COUNT-1:0] pin_ref; // Pins carrying the reference level.

    // Pin 1 sits on bit 0 and pin 2 on bit 1, the way the pad ring
    // numbers them, while the enables sit the other way round in the
    // register; the swap is made here once.
    assign pin_ref = {first_r[BIT_OE2], first_r[BIT_OE1]}; // [R6]

    // ****************************************************************
    // Pin override, one slice per reference pin.
    // ****************************************************************
    // An analogue pin must not be loaded or sensed: the output driver,
    // the pull-up and the current-controlled drive are all switched off
    // while the pin carries the level. The input stage would see noise,
    // so its reading is forced to zero; software therefore cannot tell
    // the level on such a pin, which is the intended trade.
    for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
        assign PIN_DRV_OFF[p] = pin_ref[p]; // [R7]
        assign PIN_PULLUP_OFF[p] = pin_ref[p]; // [R7]
        assign PIN_CCD_OFF[p] = pin_ref[p]; // [R7]
        assign PIN_DIG_IN[p] = PIN_IN[p] & ~pin_ref[p]; // [R7] [R8]

        // Every digital path of a reference pin is off.
        property p_pin_isolated;
            @(posedge MCLK) disable iff (!RESET_N)
            pin_ref[p] |-> !PIN_DIG_IN[p] && PIN_DRV_OFF[p]
                && PIN_PULLUP_OFF[p] && PIN_CCD_OFF[p];
        endproperty
        a_pin_isolated: assert property (p_pin_isolated) // [R7]
            else $error("Reference pin not isolated.");

        // A pin without the level is left to its digital functions.
        property p_pin_free;
            @(posedge MCLK) disable iff (!RESET_N)
            !pin_ref[p] |-> PIN_DIG_IN[p] == PIN_IN[p] && !PIN_DRV_OFF[p]
                && !PIN_PULLUP_OFF[p] && !PIN_CCD_OFF[p];
        endproperty
        a_pin_free: assert property (p_pin_free) // [R6]
            else $error("Free pin still overridden.");
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    sequence s_wr_first;
        WR && ADDR == ADDR_FIRST;
    endsequence

    property p_enable_follows;
        @(posedge MCLK) disable iff (!RESET_N)
        s_wr_first |=> LADDER.enable == $past(WDATA[BIT_ENABLE]);
    endproperty
    a_enable_follows: assert property (p_enable_follows) // [R1]
        else $error("Enable did not follow write.");

    property p_code_follows;
        @(posedge MCLK) disable iff (!RESET_N)
        (WR && ADDR == ADDR_SECOND) |=> LADDER.code == $past(WDATA[4:0]);
    endproperty
    a_code_follows: assert property (p_code_follows) // [R2]
        else $error("Level code did not follow write.");

    property p_pin_read_zero;
        @(posedge MCLK) disable iff (!RESET_N)
        LADDER.pin1_out |-> !PIN_DIG_IN[0] && PIN_DRV_OFF[0];
    endproperty
    a_pin_read_zero: assert property (p_pin_read_zero) // [R8]
        else $error("Reference pin read not zero.");

    property p_oe_follows;
        @(posedge MCLK) disable iff (!RESET_N)
        s_wr_first |=> LADDER.pin2_out == $past(WDATA[BIT_OE2]);
    endproperty
    a_oe_follows: assert property (p_oe_follows) // [R6]
        else $error("Pin enable did not follow write.");

    property p_hold_no_write;
        @(posedge MCLK) disable iff (!RESET_N)
        !WR |=> $stable(first_r) && $stable(code_r);
    endproperty
    a_hold_no_write: assert property (p_hold_no_write) // [R10]
        else $error("Settings changed without a write.");

    property p_read_first;
        @(posedge MCLK) disable iff (!RESET_N)
        (RD && ADDR == ADDR_FIRST) |=> RDATA[6] == 1'b0 && RDATA[1] == 1'b0
            && RDATA[0] == 1'b0 && RDATA[7] == LADDER.enable;
    endproperty
    a_read_first: assert property (p_read_first) // [R12]
        else $error("First register read wrong.");

    property p_negsrc_zero;
        @(posedge MCLK) disable iff (!RESET_N)
        s_wr_first |=> LADDER.neg_src == 1'b0;
    endproperty
    a_negsrc_zero: assert property (p_negsrc_zero) // [R14]
        else $error("Negative source not ground.");

    property p_pss_follows;
        @(posedge MCLK) disable iff (!RESET_N)
        s_wr_first |=> LADDER.pos_src == $past(WDATA[3:2]);
    endproperty
    a_pss_follows: assert property (p_pss_follows) // [R13]
        else $error("Source field did not follow write.");

    // The level register write also has one cycle to land.
    sequence s_wr_second;
        WR && ADDR == ADDR_SECOND;
    endsequence

    // A read of the first control register.
    sequence s_rd_first;
        RD && ADDR == ADDR_FIRST;
    endsequence

    // A read of the level register.
    sequence s_rd_second;
        RD && ADDR == ADDR_SECOND;
    endsequence

    // Any strobe at an address that holds no register.
    sequence s_unmapped;
        (WR || RD) && ADDR != ADDR_FIRST && ADDR != ADDR_SECOND;
    endsequence

    // Pin 1 enable lands together with the rest of the first register.
    property p_oe1_follows;
        @(posedge MCLK) disable iff (!RESET_N)
        s_wr_first |=> LADDER.pin1_out == $past(WDATA[BIT_OE1]);
    endproperty
    a_oe1_follows: assert property (p_oe1_follows) // [R6]
        else $error("Pin 1 enable did not follow write.");

    // A write to the level register leaves the first register alone.
    property p_second_keeps_first;
        @(posedge MCLK) disable iff (!RESET_N)
        s_wr_second |=> $stable(first_r);
    endproperty
    a_second_keeps_first: assert property (p_second_keeps_first) // [R15]
        else $error("Level write disturbed first register.");

    // The level register reads back its code, top bits clear.
    property p_read_second;
        @(posedge MCLK) disable iff (!RESET_N)
        s_rd_second |=> RDATA == {3'h0, LADDER.code};
    endproperty
    a_read_second: assert property (p_read_second) // [R2]
        else $error("Level register read wrong.");

    // Read data of the first register show exactly its stored fields.
    property p_read_fields;
        @(posedge MCLK) disable iff (!RESET_N)
        s_rd_first |=> RDATA[BIT_OE1] == LADDER.pin1_out
            && RDATA[BIT_OE2] == LADDER.pin2_out
            && RDATA[BIT_PSS_HI:BIT_PSS_LO] == LADDER.pos_src;
    endproperty
    a_read_fields: assert property (p_read_fields) // [R12]
        else $error("First register fields read wrong.");

    // Read data stand for one cycle only and are zero otherwise, so a
    // stale value cannot be mistaken for a fresh read.
    property p_rdata_idle;
        @(posedge MCLK) disable iff (!RESET_N)
        !RD |=> RDATA == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) // [R12]
        else $error("Read data outside a read.");

    // Places that hold no register neither store nor return anything.
    property p_unmapped;
        @(posedge MCLK) disable iff (!RESET_N)
        s_unmapped |=> $stable(first_r) && $stable(code_r)
            && RDATA == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) // [R12]
        else $error("Unmapped access had an effect.");

    // Sleep alone never moves a setting; the ladder runs on as it was.
    property p_sleep_keeps;
        @(posedge MCLK) disable iff (!RESET_N)
        (SLEEP && !WR) |=> $stable(LADDER);
    endproperty
    a_sleep_keeps: assert property (p_sleep_keeps) // [R9]
        else $error("Settings moved during sleep.");

    // The reserved source code is handed on as written, not decoded.
    property p_pss_raw;
        @(posedge MCLK) disable iff (!RESET_N)
        (s_wr_first ##0 WDATA[BIT_PSS_HI:BIT_PSS_LO] == PSS_RSVD)
            |=> LADDER.pos_src == PSS_RSVD;
    endproperty
    a_pss_raw: assert property (p_pss_raw) // [R13]
        else $error("Reserved source code altered.");

    // Reset leaves the converter off, both pins free and the code clear.
    // No disable clause here: this check is about reset itself, and it
    // looks at the first edge on which the release is seen.
    property p_reset_clear;
        @(posedge MCLK)
        $rose(RESET_N) |-> !LADDER.enable && !LADDER.pin1_out
            && !LADDER.pin2_out && LADDER.code == CODE_RESET;
    endproperty
    a_reset_clear: assert property (p_reset_clear) // [R11]
        else $error("Reset did not clear the settings.");
endmodule
`default_nettype wire
